// file: rtl/instr_decode_pkg.sv
// Shared constants and types for the instruction timing decoder.
// Assumes a single clock domain; nothing here holds state.
`default_nettype none
package instr_decode_pkg;

   // Opcode of no-operation and its undefined alias
   localparam logic [7:0] OP_NOP   = 8'h00;
   localparam logic [7:0] OP_UNDEF = 8'ha5;

   // Status-word bank select bit positions
   localparam int BANK_LO_POS = 3;
   localparam int BANK_HI_POS = 4;

   // Address bit that marks upper half of data space
   localparam int UPPER_HALF_BIT = 7;

   // Instruction lengths in bytes
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;

   // Cycle counts, in system clock cycles
   localparam logic [3:0] CYC_1        = 4'h1;
   localparam logic [3:0] CYC_2        = 4'h2;
   localparam logic [3:0] CYC_3        = 4'h3;
   localparam logic [3:0] CYC_COND2_T  = 4'h4;
   localparam logic [3:0] CYC_COND3_T  = 4'h5;
   localparam logic [3:0] CYC_CJIND_NT = 4'h4;
   localparam logic [3:0] CYC_CJIND_T  = 4'h6;
   localparam logic [3:0] CYC_PAGE     = 4'h4;
   localparam logic [3:0] CYC_LONG     = 4'h5;
   localparam logic [3:0] CYC_RETURN   = 4'h6;
   localparam logic [3:0] CYC_MUL      = 4'h4;
   localparam logic [3:0] CYC_DIV      = 4'h8;

   // Kind of control transfer
   typedef enum logic [3:0] {
      XF_NONE      = 4'h0,
      XF_PAGE_JUMP = 4'h1,
      XF_PAGE_CALL = 4'h2,
      XF_LONG_JUMP = 4'h3,
      XF_LONG_CALL = 4'h4,
      XF_SHORT     = 4'h5,
      XF_IND_JUMP  = 4'h6,
      XF_RET       = 4'h7,
      XF_INTERRUPT_RETURN      = 4'h8,
      XF_COND      = 4'h9
   } xfer_class_t;

   // Branch condition kinds
   typedef enum logic [3:0] {
      CND_NONE     = 4'h0,
      CND_CARRY    = 4'h1,
      CND_NCARRY   = 4'h2,
      CND_ZERO     = 4'h3,
      CND_NZERO    = 4'h4,
      CND_BIT      = 4'h5,
      CND_NBIT     = 4'h6,
      CND_BITCLR   = 4'h7,
      CND_NE_DIR   = 4'h8,
      CND_NE_IMM   = 4'h9,
      CND_NE_IND   = 4'ha,
      CND_NE_REG   = 4'hb,
      CND_DECREMENT_JUMP_NONZERO_REG = 4'hc,
      CND_DECREMENT_JUMP_NONZERO_DIR = 4'hd
   } cond_kind_t;

   // One row of the timing table
   typedef struct packed {
      logic [1:0]  len;
      logic [3:0]  cyc_nt;
      logic [3:0]  cyc_t;
      xfer_class_t cls;
      cond_kind_t  cond;
   } timing_entry_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01
   } seq_state_t;

endpackage
`default_nettype wire

// file: rtl/opcode_timing_table.sv
// Opcode to length, cycle count and transfer kind lookup.
// Purely combinational; the caller registers what it needs.
`default_nettype none
module opcode_timing_table (
   // Opcode in
   input  wire logic [7:0]                     opcode,
   // Table row out
   output instr_decode_pkg::timing_entry_t     entry
);

   function automatic instr_decode_pkg::timing_entry_t ent(
      input logic [1:0]                   l,
      input logic [3:0]                   nt,
      input logic [3:0]                   t,
      input instr_decode_pkg::xfer_class_t c,
      input instr_decode_pkg::cond_kind_t  k);
      instr_decode_pkg::timing_entry_t e;
      e.len    = l;
      e.cyc_nt = nt;
      e.cyc_t  = t;
      e.cls    = c;
      e.cond   = k;
      return e;
   endfunction

   localparam logic [1:0] L1 = instr_decode_pkg::LEN_1;
   localparam logic [1:0] L2 = instr_decode_pkg::LEN_2;
   localparam logic [1:0] L3 = instr_decode_pkg::LEN_3;
   localparam logic [3:0] C1 = instr_decode_pkg::CYC_1;
   localparam logic [3:0] C2 = instr_decode_pkg::CYC_2;
   localparam logic [3:0] C3 = instr_decode_pkg::CYC_3;
   localparam logic [3:0] T4 = instr_decode_pkg::CYC_COND2_T;
   localparam logic [3:0] T5 = instr_decode_pkg::CYC_COND3_T;
   localparam instr_decode_pkg::xfer_class_t XN = instr_decode_pkg::XF_NONE;
   localparam instr_decode_pkg::xfer_class_t XC = instr_decode_pkg::XF_COND;
   localparam instr_decode_pkg::cond_kind_t  KN = instr_decode_pkg::CND_NONE;

   always_comb begin
      entry = ent(L1, C1, C1, XN, KN);
      casez (opcode)
         instr_decode_pkg::OP_NOP,
         instr_decode_pkg::OP_UNDEF: entry = ent(L1, C1, C1, XN, KN);
         8'b???00001: entry = ent(L2, instr_decode_pkg::CYC_PAGE,
            instr_decode_pkg::CYC_PAGE, instr_decode_pkg::XF_PAGE_JUMP, KN);
         8'b???10001: entry = ent(L2, instr_decode_pkg::CYC_PAGE,
            instr_decode_pkg::CYC_PAGE, instr_decode_pkg::XF_PAGE_CALL, KN);
         8'h02: entry = ent(L3, instr_decode_pkg::CYC_LONG,
            instr_decode_pkg::CYC_LONG, instr_decode_pkg::XF_LONG_JUMP, KN);
         8'h12: entry = ent(L3, instr_decode_pkg::CYC_LONG,
            instr_decode_pkg::CYC_LONG, instr_decode_pkg::XF_LONG_CALL, KN);
         8'h22: entry = ent(L1, instr_decode_pkg::CYC_RETURN,
            instr_decode_pkg::CYC_RETURN, instr_decode_pkg::XF_RET, KN);
         8'h32: entry = ent(L1, instr_decode_pkg::CYC_RETURN,
            instr_decode_pkg::CYC_RETURN, instr_decode_pkg::XF_INTERRUPT_RETURN, KN);
         8'h80: entry = ent(L2, instr_decode_pkg::CYC_PAGE,
            instr_decode_pkg::CYC_PAGE, instr_decode_pkg::XF_SHORT, KN);
         8'h73: entry = ent(L1, instr_decode_pkg::CYC_PAGE,
            instr_decode_pkg::CYC_PAGE, instr_decode_pkg::XF_IND_JUMP, KN);
         // Conditional jumps
         8'h40: entry = ent(L2, C2, T4, XC, instr_decode_pkg::CND_CARRY);
         8'h50: entry = ent(L2, C2, T4, XC, instr_decode_pkg::CND_NCARRY);
         8'h60: entry = ent(L2, C2, T4, XC, instr_decode_pkg::CND_ZERO);
         8'h70: entry = ent(L2, C2, T4, XC, instr_decode_pkg::CND_NZERO);
         8'b11011???: entry = ent(L2, C2, T4, XC,
            instr_decode_pkg::CND_DECREMENT_JUMP_NONZERO_REG);
         8'h20: entry = ent(L3, C3, T5, XC, instr_decode_pkg::CND_BIT);
         8'h30: entry = ent(L3, C3, T5, XC, instr_decode_pkg::CND_NBIT);
         8'h10: entry = ent(L3, C3, T5, XC, instr_decode_pkg::CND_BITCLR);
         8'hb5: entry = ent(L3, C3, T5, XC, instr_decode_pkg::CND_NE_DIR);
         8'hb4: entry = ent(L3, C3, T5, XC, instr_decode_pkg::CND_NE_IMM);
         8'b10111???: entry = ent(L3, C3, T5, XC,
            instr_decode_pkg::CND_NE_REG);
         8'hd5: entry = ent(L3, C3, T5, XC, instr_decode_pkg::CND_DECREMENT_JUMP_NONZERO_DIR);
         8'b1011011?: entry = ent(L3, instr_decode_pkg::CYC_CJIND_NT,
            instr_decode_pkg::CYC_CJIND_T, XC,
            instr_decode_pkg::CND_NE_IND);
         // Multi-cycle moves and arithmetic
         8'he0, 8'hf0, 8'b111?001?: entry = ent(L1, C3, C3, XN, KN);
         8'h83, 8'h93: entry = ent(L1, C3, C3, XN, KN);
         8'h90: entry = ent(L3, C3, C3, XN, KN);
         8'ha4: entry = ent(L1, instr_decode_pkg::CYC_MUL,
            instr_decode_pkg::CYC_MUL, XN, KN);
         8'h84: entry = ent(L1, instr_decode_pkg::CYC_DIV,
            instr_decode_pkg::CYC_DIV, XN, KN);
         // Three-byte direct forms
         8'h43, 8'h53, 8'h63, 8'h75, 8'h85: entry = ent(L3, C3, C3, XN, KN);
         // Register forms with an operand byte
         8'b01111???, 8'b10001???, 8'b10101???:
            entry = ent(L2, C2, C2, XN, KN);
         8'b????1???: entry = ent(L1, C1, C1, XN, KN);
         // Indirect forms with an operand byte
         8'b0111011?, 8'b1000011?, 8'b1010011?:
            entry = ent(L2, C2, C2, XN, KN);
         8'b????011?: entry = ent(L1, C2, C2, XN, KN);
         // Accumulator, carry and rotate one-byte forms
         8'h04, 8'h14, 8'hc4, 8'hd4, 8'he4, 8'hf4, 8'h03, 8'h13, 8'h23,
         8'h33, 8'ha3: entry = ent(L1, C1, C1, XN, KN);
         8'hb3, 8'hc3, 8'hd3: entry = ent(L1, C1, C1, XN, KN);
         8'ha0, 8'hb0, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2, 8'hc2, 8'hd2:
            entry = ent(L2, C2, C2, XN, KN);
         8'hc0, 8'hd0: entry = ent(L2, C2, C2, XN, KN);
         // Remaining two-byte direct and immediate forms
         8'b????0100, 8'b????0101, 8'b????0010:
            entry = ent(L2, C2, C2, XN, KN);
         default: entry = ent(L1, C1, C1, XN, KN);
      endcase
   end

endmodule
`default_nettype wire

// file: rtl/cpu_instruction_timing_decode.sv
// Instruction decode and cycle timing for an 8-bit accumulator core.
// Assumes opcode and both following bytes are present at fetch, and that
// operand values read by the core are valid in the same cycle.
//
// What this block does
// - Register operand address uses active bank
// - Indirect address from bank R0 or R1
// - Signed offset added to next address
// - Direct lower half RAM, upper half SFR
// - Page target replaces low eleven bits
// - Long target loads full program counter
// - Undefined opcode behaves as one-cycle NOP
// - Two-byte conditional jumps take two or four
// - Three-byte conditional jumps take three or five, except indirect compare
// - Bit jump clears tested bit when taken
// - Indirect compare jump takes four or six
// - Unconditional transfers take four, five, six
// - External data moves: one byte, three cycles
// - Code memory read: one byte, three cycles
// - Data pointer immediate load: three cycles
// - Indirect one-byte operations take two cycles
// - Accumulator and register ops take one cycle
// - Direct forms two cycles, three-byte three
// - Low nibble exchange swaps bits three-zero
// - Carry ops one cycle, bit ops two
// - Push and pop direct take two cycles
// - Status bits three and four pick bank
// - Indirect upper addresses reach upper RAM
`default_nettype none
module cpu_instruction_timing_decode (
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // Fetch
   input  wire logic        FETCH_VALID,
   output logic             FETCH_READY,
   input  wire logic [15:0] INSTR_PC,
   input  wire logic [7:0]  OPCODE,
   input  wire logic [7:0]  OPND1,
   input  wire logic [7:0]  OPND2,
   // Core state
   input  wire logic [7:0]  STATUS_WORD,
   input  wire logic        CARRY,
   input  wire logic [7:0]  ACC,
   input  wire logic [15:0] DATA_POINTER,
   input  wire logic [15:0] RETURN_ADDR,
   // Operand values
   input  wire logic [7:0]  PTR_VALUE,
   input  wire logic [7:0]  REG_VALUE,
   input  wire logic [7:0]  DIRECT_VALUE,
   input  wire logic [7:0]  IND_VALUE,
   input  wire logic        BIT_VALUE,
   // Decode result
   output logic             DECODE_VALID,
   output logic [1:0]       INSTR_LEN,
   output logic [3:0]       INSTR_CYCLES,
   output logic             BRANCH_TAKEN,
   output logic [15:0]      NEXT_PC,
   // Operand addresses
   output logic [7:0]       REG_ADDR,
   output logic [7:0]       PTR_ADDR,
   output logic [7:0]       DIRECT_ADDR,
   output logic             DIRECT_TO_SFR,
   output logic             IND_UPPER_RAM,
   // Side effects
   output logic             BIT_CLEAR,
   output logic [7:0]       NIBBLE_ACC,
   output logic [7:0]       NIBBLE_RAM,
   output logic [7:0]       DEC_RESULT,
   output logic             CMP_CARRY,
   output logic             PC_PUSH,
   output logic             PC_POP,
   output logic             INT_RETURN,
   // External and code memory access
   output logic [15:0]      EXT_ADDR,
   output logic             EXT_RD,
   output logic             EXT_WR,
   output logic             CODE_RD
);

   instr_decode_pkg::timing_entry_t entry;
   instr_decode_pkg::seq_state_t    state_r;
   instr_decode_pkg::seq_state_t    state_nxt;

   logic [3:0]  cnt_r;
   logic [3:0]  cnt_nxt;
   logic        accept;
   logic [1:0]  bank;
   logic [15:0] next_seq;
   logic [7:0]  rel;
   logic [15:0] rel_target;
   logic [15:0] page_target;
   logic [15:0] long_target;
   logic [15:0] ind_target;
   logic [15:0] code_pc_addr;
   logic [15:0] xfer_target;
   logic        cond_true;
   logic        taken;
   logic [3:0]  cycles_sel;
   logic [7:0]  dec_value;
   logic        is_exchange_low_nibble;
   logic        is_ext_ri;
   logic        is_ext_data_pointer_16;
   logic        is_ext_wr;
   logic        is_code_rd;
   logic        cmp_lt;
   logic [7:0]  cmp_lhs;
   logic [7:0]  cmp_rhs;

   opcode_timing_table u_table (
      .opcode (OPCODE),
      .entry  (entry)
   );

   // Register bank and operand addressing
   assign bank = {STATUS_WORD[instr_decode_pkg::BANK_HI_POS],
                  STATUS_WORD[instr_decode_pkg::BANK_LO_POS]};

   // Address sequencing
   assign next_seq    = 16'(INSTR_PC + {14'h0000, entry.len});
   assign rel         = (entry.len == instr_decode_pkg::LEN_2) ? OPND1 : OPND2;
   assign rel_target  = 16'(next_seq + {{8{rel[7]}}, rel});
   assign page_target = {next_seq[15:11], OPCODE[7:5], OPND1};
   assign long_target = {OPND1, OPND2};
   assign ind_target  = 16'(DATA_POINTER + {8'h00, ACC});
   assign code_pc_addr = 16'(next_seq + {8'h00, ACC});

   // Condition evaluation
   assign dec_value = 8'(((entry.cond == instr_decode_pkg::CND_DECREMENT_JUMP_NONZERO_REG)
                          ? REG_VALUE : DIRECT_VALUE) - 8'h01);

   always_comb begin
      cmp_lhs = ACC;
      cmp_rhs = OPND1;
      case (entry.cond)
         instr_decode_pkg::CND_NE_DIR: cmp_rhs = DIRECT_VALUE;
         instr_decode_pkg::CND_NE_IND: cmp_lhs = IND_VALUE;
         instr_decode_pkg::CND_NE_REG: cmp_lhs = REG_VALUE;
         default: cmp_rhs = OPND1;
      endcase
   end

   assign cmp_lt = (cmp_lhs < cmp_rhs);

   always_comb begin
      cond_true = 1'b0;
      case (entry.cond)
         instr_decode_pkg::CND_CARRY:    cond_true = CARRY;
         instr_decode_pkg::CND_NCARRY:   cond_true = ~CARRY;
         instr_decode_pkg::CND_ZERO:     cond_true = (ACC == 8'h00);
         instr_decode_pkg::CND_NZERO:    cond_true = (ACC != 8'h00);
         instr_decode_pkg::CND_BIT:      cond_true = BIT_VALUE;
         instr_decode_pkg::CND_NBIT:     cond_true = ~BIT_VALUE;
         instr_decode_pkg::CND_BITCLR:   cond_true = BIT_VALUE;
         instr_decode_pkg::CND_NE_DIR,
         instr_decode_pkg::CND_NE_IMM,
         instr_decode_pkg::CND_NE_IND,
         instr_decode_pkg::CND_NE_REG:   cond_true = (cmp_lhs != cmp_rhs);
         instr_decode_pkg::CND_DECREMENT_JUMP_NONZERO_REG,
         instr_decode_pkg::CND_DECREMENT_JUMP_NONZERO_DIR: cond_true = (dec_value != 8'h00);
         default:                        cond_true = 1'b0;
      endcase
   end

   assign taken = (entry.cls != instr_decode_pkg::XF_NONE) &&
                  ((entry.cls != instr_decode_pkg::XF_COND) || cond_true);

   // Taken branches use the longer count
   assign cycles_sel = taken ? entry.cyc_t : entry.cyc_nt;

   always_comb begin
      xfer_target = next_seq;
      case (entry.cls)
         instr_decode_pkg::XF_PAGE_JUMP,
         instr_decode_pkg::XF_PAGE_CALL: xfer_target = page_target;
         instr_decode_pkg::XF_LONG_JUMP,
         instr_decode_pkg::XF_LONG_CALL: xfer_target = long_target;
         instr_decode_pkg::XF_SHORT:     xfer_target = rel_target;
         instr_decode_pkg::XF_COND:
            xfer_target = cond_true ? rel_target : next_seq;
         instr_decode_pkg::XF_IND_JUMP:  xfer_target = ind_target;
         instr_decode_pkg::XF_RET,
         instr_decode_pkg::XF_INTERRUPT_RETURN:      xfer_target = RETURN_ADDR;
         default:                        xfer_target = next_seq;
      endcase
   end

   // Memory access classes
   assign is_exchange_low_nibble     = (OPCODE[7:1] == 7'b1101_011);
   assign is_ext_ri   = (OPCODE[7:5] == 3'b111) && (OPCODE[3:1] == 3'b001);
   assign is_ext_data_pointer_16 = (OPCODE[7:5] == 3'b111) && (OPCODE[3:0] == 4'h0);
   assign is_ext_wr   = OPCODE[4];
   assign is_code_rd  = (OPCODE == 8'h83) || (OPCODE == 8'h93);

   // Instruction sequencer
   assign FETCH_READY = (cnt_r == 4'h0);
   assign accept      = FETCH_VALID && FETCH_READY;

   always_comb begin
      cnt_nxt = cnt_r;
      if (accept) begin
         cnt_nxt = 4'(cycles_sel - 4'h1);
      end else if (cnt_r != 4'h0) begin
         cnt_nxt = 4'(cnt_r - 4'h1);
      end
   end

   always_comb begin
      case (state_r)
         instr_decode_pkg::ST_IDLE,
         instr_decode_pkg::ST_EXEC:
            state_nxt = (cnt_nxt != 4'h0) ? instr_decode_pkg::ST_EXEC
                                          : instr_decode_pkg::ST_IDLE;
         default: state_nxt = instr_decode_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_r <= instr_decode_pkg::ST_IDLE;
         cnt_r   <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Strobes: one cycle after the fetch is taken
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         DECODE_VALID <= 1'b0;
         BIT_CLEAR    <= 1'b0;
         PC_PUSH      <= 1'b0;
         PC_POP       <= 1'b0;
         INT_RETURN   <= 1'b0;
         EXT_RD       <= 1'b0;
         EXT_WR       <= 1'b0;
         CODE_RD      <= 1'b0;
      end else begin
         DECODE_VALID <= accept;
         BIT_CLEAR    <= accept && (entry.cond == instr_decode_pkg::CND_BITCLR)
                         && BIT_VALUE;
         PC_PUSH      <= accept &&
                         ((entry.cls == instr_decode_pkg::XF_PAGE_CALL) ||
                          (entry.cls == instr_decode_pkg::XF_LONG_CALL));
         PC_POP       <= accept &&
                         ((entry.cls == instr_decode_pkg::XF_RET) ||
                          (entry.cls == instr_decode_pkg::XF_INTERRUPT_RETURN));
         INT_RETURN   <= accept && (entry.cls == instr_decode_pkg::XF_INTERRUPT_RETURN);
         EXT_RD       <= accept && (is_ext_ri || is_ext_data_pointer_16) && !is_ext_wr;
         EXT_WR       <= accept && (is_ext_ri || is_ext_data_pointer_16) && is_ext_wr;
         CODE_RD      <= accept && is_code_rd;
      end
   end

   // Decode data: held until the next fetch is taken
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         INSTR_LEN    <= 2'h0;
         INSTR_CYCLES <= 4'h0;
         BRANCH_TAKEN <= 1'b0;
         NEXT_PC      <= 16'h0000;
      end else if (accept) begin
         INSTR_LEN    <= entry.len;
         INSTR_CYCLES <= cycles_sel;
         BRANCH_TAKEN <= taken;
         NEXT_PC      <= xfer_target;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         REG_ADDR      <= 8'h00;
         PTR_ADDR      <= 8'h00;
         DIRECT_ADDR   <= 8'h00;
         DIRECT_TO_SFR <= 1'b0;
         IND_UPPER_RAM <= 1'b0;
      end else if (accept) begin
         REG_ADDR      <= {3'b000, bank, OPCODE[2:0]};
         PTR_ADDR      <= {3'b000, bank, 2'b00, OPCODE[0]};
         DIRECT_ADDR   <= OPND1;
         DIRECT_TO_SFR <= OPND1[instr_decode_pkg::UPPER_HALF_BIT];
         IND_UPPER_RAM <= PTR_VALUE[instr_decode_pkg::UPPER_HALF_BIT];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         NIBBLE_ACC <= 8'h00;
         NIBBLE_RAM <= 8'h00;
         DEC_RESULT <= 8'h00;
         CMP_CARRY  <= 1'b0;
      end else if (accept) begin
         NIBBLE_ACC <= is_exchange_low_nibble ? {ACC[7:4], IND_VALUE[3:0]} : ACC;
         NIBBLE_RAM <= is_exchange_low_nibble ? {IND_VALUE[7:4], ACC[3:0]}
                               : IND_VALUE;
         DEC_RESULT <= dec_value;
         CMP_CARRY  <= cmp_lt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         EXT_ADDR <= 16'h0000;
      end else if (accept) begin
         if (is_ext_ri) begin
            EXT_ADDR <= {8'h00, PTR_VALUE};
         end else if (is_ext_data_pointer_16) begin
            EXT_ADDR <= DATA_POINTER;
         end else if (OPCODE == 8'h93) begin
            EXT_ADDR <= ind_target;
         end else begin
            EXT_ADDR <= code_pc_addr;
         end
      end
   end

endmodule
`default_nettype wire

// file: dv/decode_monitor.sv
// Port-level assertions for the instruction timing decoder.
// Assumes one clock domain; bound to every decoder instance.
`default_nettype none
module decode_monitor (
   // Clock, reset and fetch
   input wire logic        CORE_CLK, RST, FETCH_VALID, FETCH_READY,
   input wire logic [15:0] INSTR_PC, NEXT_PC,
   input wire logic [7:0]  OPCODE, OPND1, OPND2, STATUS_WORD, PTR_VALUE,
   input wire logic        BIT_VALUE, DECODE_VALID, BRANCH_TAKEN,
   // Decode result
   input wire logic [1:0]  INSTR_LEN,
   input wire logic [3:0]  INSTR_CYCLES,
   input wire logic [7:0]  REG_ADDR, PTR_ADDR, DIRECT_ADDR,
   input wire logic        DIRECT_TO_SFR, IND_UPPER_RAM, BIT_CLEAR
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic  take = FETCH_VALID && FETCH_READY;
   logic [7:0] op_r, o1_r, o2_r, sw_r, pv_r;
   logic       bv_r;
   always_ff @(posedge CORE_CLK) begin
      {op_r, o1_r, o2_r} <= {OPCODE, OPND1, OPND2};
      {sw_r, pv_r, bv_r} <= {STATUS_WORD, PTR_VALUE, BIT_VALUE};
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   chk_answer_next: assert property (take |=> DECODE_VALID)
      else $error("decode strobe missing");
   chk_no_spurious: assert property (!take |=> !DECODE_VALID)
      else $error("decode strobe without fetch");
   chk_ready_one: assert property (DECODE_VALID && INSTR_CYCLES == 4'h1
      |-> FETCH_READY) else $error("one-cycle op stalls");
   chk_ready_four: assert property (DECODE_VALID && INSTR_CYCLES == 4'h4
      |-> !FETCH_READY [*3] ##1 FETCH_READY) else $error("four-cycle gap");
   chk_ready_six: assert property (DECODE_VALID && INSTR_CYCLES == 4'h6
      |-> !FETCH_READY [*5] ##1 FETCH_READY) else $error("six-cycle gap");
   chk_bank_reg: assert property (DECODE_VALID
      |-> REG_ADDR == {3'h0, sw_r[4:3], op_r[2:0]}) else $error("reg addr");
   chk_ptr_addr: assert property (DECODE_VALID
      |-> PTR_ADDR == {3'h0, sw_r[4:3], 2'h0, op_r[0]}) else $error("ptr");
   chk_direct_sfr: assert property (DECODE_VALID
      |-> DIRECT_TO_SFR == o1_r[7] && DIRECT_ADDR == o1_r)
      else $error("direct space select");
   chk_upper_ram: assert property (take |=> IND_UPPER_RAM == pv_r[7])
      else $error("indirect upper select");
   chk_nop_alias: assert property (DECODE_VALID && op_r == 8'ha5
      |-> INSTR_CYCLES == 4'h1 && INSTR_LEN == 2'h1 && !BRANCH_TAKEN)
      else $error("undefined opcode timing");
   chk_long_target: assert property (DECODE_VALID && op_r == 8'h02
      |-> NEXT_PC == {o1_r, o2_r}) else $error("long target");
   chk_bit_clear: assert property (DECODE_VALID && op_r == 8'h10
      |-> BIT_CLEAR == bv_r && BRANCH_TAKEN == bv_r) else $error("bit clear");
endmodule
bind cpu_instruction_timing_decode decode_monitor mon (.*);
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench: random operands over a table of opcodes.
// Assumes the decoder and its bound checker are compiled first.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CORE_CLK = 0, RST = 1, FETCH_VALID = 0, CARRY = 0;
   logic        BIT_VALUE = 0, FETCH_READY, DECODE_VALID, BRANCH_TAKEN;
   logic        EXT_RD;
   logic [7:0]  OPCODE = 0, OPND1 = 0, OPND2 = 0, STATUS_WORD = 0, ACC = 0;
   logic [7:0]  PTR_VALUE = 0, REG_VALUE = 0, DIRECT_VALUE = 0;
   logic [7:0]  IND_VALUE = 0, NIBBLE_ACC, NIBBLE_RAM;
   logic [15:0] INSTR_PC = 0, DATA_POINTER = 0, RETURN_ADDR = 0, NEXT_PC;
   logic [1:0]  INSTR_LEN;
   logic [3:0]  INSTR_CYCLES;
   int          bad_count = 0, n_tests = 0;
   // Opcode, length, cycles when not taken
   logic [15:0] tbl [] = '{16'h0011, 16'ha511, 16'h4022, 16'h5022,
      16'h6022, 16'h7022, 16'hd822, 16'h2033, 16'h3033, 16'h1033, 16'hb433,
      16'hb533, 16'hb833, 16'hb634, 16'hd533, 16'h1124, 16'h0124, 16'h2124,
      16'hf124, 16'h8024, 16'h7314, 16'h1235, 16'h0235, 16'h2216, 16'h3216,
      16'he013, 16'he213, 16'hf013, 16'hf313, 16'h9313, 16'h8313, 16'h9033,
      16'he612, 16'hd612, 16'hc612, 16'h4612, 16'he411, 16'hf411, 16'h2311,
      16'h3311, 16'h0311, 16'h1311, 16'hc411, 16'he811, 16'hcb11, 16'he522,
      16'h7422, 16'h8533, 16'h7533, 16'h4333, 16'h6222, 16'hc311, 16'hd311,
      16'hb311, 16'hc222, 16'hd222, 16'hb222, 16'h9222, 16'ha222, 16'h8222,
      16'hb022, 16'h7222, 16'hc022, 16'hd022};
   cpu_instruction_timing_decode dut (.*, .REG_ADDR(), .PTR_ADDR(),
      .DIRECT_ADDR(), .DIRECT_TO_SFR(), .IND_UPPER_RAM(), .BIT_CLEAR(),
      .DEC_RESULT(), .CMP_CARRY(), .PC_PUSH(), .PC_POP(), .INT_RETURN(),
      .EXT_ADDR(), .EXT_WR(), .CODE_RD());
   initial forever #10 CORE_CLK = ~CORE_CLK;
   // Conditional flag and taken flag
   function automatic logic [1:0] cond_of(logic [7:0] op);
      casez (op)
         8'h40: return {1'b1, CARRY};
         8'h50: return {1'b1, !CARRY};
         8'h60: return {1'b1, ACC == 8'h00};
         8'h70: return {1'b1, ACC != 8'h00};
         8'h10, 8'h20: return {1'b1, BIT_VALUE};
         8'h30: return {1'b1, !BIT_VALUE};
         8'hb4: return {1'b1, ACC != OPND1};
         8'hb5: return {1'b1, ACC != DIRECT_VALUE};
         8'hb6: return {1'b1, IND_VALUE != OPND1};
         8'hb8: return {1'b1, REG_VALUE != OPND1};
         8'hd8: return {1'b1, REG_VALUE != 8'h01};
         8'hd5: return {1'b1, DIRECT_VALUE != 8'h01};
         8'b????0001, 8'h80, 8'h73, 8'h12, 8'h02, 8'h22, 8'h32: return 2'b01;
         default: return 2'b00;
      endcase
   endfunction
   function automatic logic [15:0] pc_of(logic [7:0] op, logic [1:0] len,
                                        logic [1:0] c);
      logic [15:0] np;
      logic [7:0]  rel;
      np = INSTR_PC + 16'(len);
      rel = (len == 2'h2) ? OPND1 : OPND2;
      if (!c[0]) return np;
      casez (op)
         8'b????0001: return {np[15:11], op[7:5], OPND1};
         8'h12, 8'h02: return {OPND1, OPND2};
         8'h22, 8'h32: return RETURN_ADDR;
         8'h73: return DATA_POINTER + 16'(ACC);
         default: return np + {{8{rel[7]}}, rel};
      endcase
   endfunction
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(logic [15:0] e, int p);
      logic [1:0] c;
      logic [3:0] ec;
      int         lows;
      @(negedge CORE_CLK);
      OPCODE = e[15:8];
      INSTR_PC = (p == 0) ? 16'h07fe : 16'($urandom);
      {OPND1, OPND2, ACC, STATUS_WORD} = $urandom;
      {PTR_VALUE, REG_VALUE, DIRECT_VALUE, IND_VALUE} = $urandom;
      {DATA_POINTER, RETURN_ADDR} = $urandom;
      {CARRY, BIT_VALUE} = 2'($urandom);
      if (p[0]) {OPND1, ACC, REG_VALUE, DIRECT_VALUE, IND_VALUE} =
         {5{8'h01}} & {OPND1, ACC, REG_VALUE, DIRECT_VALUE, IND_VALUE};
      c = cond_of(OPCODE);
      ec = e[3:0] + ((c == 2'b11) ? 4'h2 : 4'h0);
      FETCH_VALID = 1;
      @(negedge CORE_CLK);
      FETCH_VALID = 0;
      check(DECODE_VALID, 1);
      check(INSTR_LEN, e[7:4]);
      check(INSTR_CYCLES, ec);
      check(BRANCH_TAKEN, c[0]);
      check(NEXT_PC, pc_of(OPCODE, e[5:4], c));
      check(EXT_RD, OPCODE inside {8'he0, 8'he2, 8'he3});
      if (OPCODE == 8'hd6) check({NIBBLE_ACC, NIBBLE_RAM},
         {ACC[7:4], IND_VALUE[3:0], IND_VALUE[7:4], ACC[3:0]});
      lows = 0;
      while (FETCH_READY !== 1'b1 && lows < 9) begin
         lows++;
         @(negedge CORE_CLK);
      end
      check(lows, ec - 4'h1);
   endtask
   task automatic test_done();
      if (bad_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      void'($urandom(28));
      repeat (6) @(posedge CORE_CLK);
      @(negedge CORE_CLK) RST = 0;
      check({FETCH_READY, DECODE_VALID}, 2'b10);
      for (int p = 0; p < 6; p++) foreach (tbl[i]) run(tbl[i], p);
      test_done();
   end
   initial begin
      #400000;
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire
